/* design/cajc_pkg.sv */
// package: shared constants for aux acknowledge and axis jog control
package cajc_pkg;
    // channel interface byte offsets, channel one at base
    localparam logic [7:0] CAJC_OFS_AUX_ACK = 8'h6d;
    localparam logic [7:0] CAJC_OFS_ASUB = 8'h6e;
    localparam logic [7:0] CAJC_OFS_GEO1 = 8'h72;
    localparam logic [7:0] CAJC_OFS_GEO2 = 8'h73;
    localparam logic [7:0] CAJC_OFS_GEO3 = 8'h74;
    localparam logic [7:0] CAJC_OFS_ORI1 = 8'h75;
    // designer status registers
    localparam logic [7:0] CAJC_OFS_STATUS = 8'h76;
    localparam logic [7:0] CAJC_OFS_AUX_CMD = 8'h77;
    // per-channel displacement
    localparam int CAJC_CHAN_STRIDE = 100;
    localparam int CAJC_NUM_AXES = 4;
    localparam int CAJC_NUM_GEO = 3;
    // bit positions inside an axis control byte, the aux acknowledge byte and the subprogram byte
    localparam int CAJC_BIT_FEED_HALT = 3;
    localparam int CAJC_BIT_INHIBIT = 4;
    localparam int CAJC_BIT_RAPID_OVR = 5;
    localparam int CAJC_BIT_JOG_NEG = 6;
    localparam int CAJC_BIT_JOG_POS = 7;
    localparam int CAJC_BIT_ACK = 0;
    localparam int CAJC_BIT_ASUB = 7;
    localparam logic [7:0] CAJC_BYTE_RESET = 8'h00;
    typedef enum logic [1:0] {
        CAJC_RUN = 2'b00,
        CAJC_WAIT_ACK = 2'b01
    } cajc_chan_state_e;
endpackage : cajc_pkg

/* design/cajc_if.sv */
// interface: controller-to-channel interface bits
`timescale 1ns/1ps
`default_nettype none
interface cajc_if;
    import cajc_pkg::*;
    logic aux_function_acknowledge;
    logic async_subprogram_launch;
    logic [7:0] axis_ctrl [CAJC_NUM_AXES];
    logic aux_pending;
    logic jog_conflict;
    modport device (
        input aux_function_acknowledge,
        input async_subprogram_launch,
        input axis_ctrl,
        output aux_pending,
        output jog_conflict
    );
    modport host (
        output aux_function_acknowledge,
        output async_subprogram_launch,
        output axis_ctrl,
        input aux_pending,
        input jog_conflict
    );
endinterface : cajc_if
`default_nettype wire

/* design/cajc_channel.sv */
// module: channel end acting on aux acknowledge and axis control bits
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - acknowledge is edge; rising only counts
// - actions held pending until aux acknowledged
// - program resumes after acknowledge edge
// - axis byte bits three to seven
// - feed halt maps to axis feed stop
// - inhibit blocks jog requests in jog
// - rapid override maps to axis enable
// - one geometry axis jogging negative
// - one geometry axis jogging positive
// - channel offset displaced by 100
module cajc_channel
    import cajc_pkg::*;
#(
    parameter int CHAN_INDEX = 0
) (
    input wire logic clk,
    input wire logic rst,
    cajc_if.device link,
    input wire logic aux_output,
    input wire logic action_req,
    input wire logic jog_mode,
    output logic program_run,
    output logic action_grant,
    output logic [CAJC_NUM_AXES-1:0] feed_halt,
    output logic [CAJC_NUM_AXES-1:0] rapid_override_enable,
    output logic [CAJC_NUM_AXES-1:0] jog_negative,
    output logic [CAJC_NUM_AXES-1:0] jog_positive,
    output logic [15:0] chan_base
);

    // ==========================================================
    // acknowledge handshake
    cajc_chan_state_e state_r, state_nxt;
    logic ack_d_r, ack_d_nxt;
    logic run_r, run_nxt;
    logic grant_r, grant_nxt;
    logic hold_r, hold_nxt;
    logic pend_r, pend_nxt;
    logic ack_edge;

    always_comb begin
        // host drives the bit on this clock, no synchroniser
        ack_d_nxt = link.aux_function_acknowledge;
        // rising edge detect
        ack_edge = link.aux_function_acknowledge & ~ack_d_r;
        state_nxt = state_r;
        run_nxt = run_r;
        grant_nxt = 1'b0;
        hold_nxt = hold_r;
        case (state_r)
            CAJC_RUN: begin
                run_nxt = 1'b1;
                if (aux_output) begin
                    state_nxt = CAJC_WAIT_ACK;
                    run_nxt = 1'b0;
                    hold_nxt = hold_r | action_req;
                end else begin
                    grant_nxt = action_req | hold_r;
                    hold_nxt = 1'b0;
                end
            end
            CAJC_WAIT_ACK: begin
                run_nxt = 1'b0;
                // several deferred requests give one grant
                hold_nxt = hold_r | action_req;
                if (ack_edge) begin
                    state_nxt = CAJC_RUN;
                    run_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = CAJC_RUN;
                run_nxt = 1'b1;
                hold_nxt = 1'b0;
            end
        endcase
        // pending flag kept in its own register
        pend_nxt = (state_nxt == CAJC_WAIT_ACK);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= CAJC_RUN;
            ack_d_r <= 1'b0;
            run_r <= 1'b0;
            grant_r <= 1'b0;
            hold_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ack_d_r <= ack_d_nxt;
            run_r <= run_nxt;
            grant_r <= grant_nxt;
            hold_r <= hold_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ==========================================================
    // axis control decode
    logic [CAJC_NUM_AXES-1:0] fh_nxt;
    logic [CAJC_NUM_AXES-1:0] ro_nxt;
    logic [CAJC_NUM_AXES-1:0] jn_nxt;
    logic [CAJC_NUM_AXES-1:0] jp_nxt;
    logic [CAJC_NUM_AXES-1:0] req_n;
    logic [CAJC_NUM_AXES-1:0] req_p;
    logic [CAJC_NUM_AXES-1:0] fh_r;
    logic [CAJC_NUM_AXES-1:0] ro_r;
    logic [CAJC_NUM_AXES-1:0] jn_r;
    logic [CAJC_NUM_AXES-1:0] jp_r;
    logic conflict_nxt;
    logic conflict_r;
    logic [15:0] base_nxt;
    logic [15:0] base_r;
    logic [CAJC_NUM_AXES-1:0] used_n;
    logic [CAJC_NUM_AXES-1:0] used_p;

    genvar g;
    generate
        for (g = 0; g < CAJC_NUM_AXES; g++) begin : g_axis
            assign fh_nxt[g] = link.axis_ctrl[g][CAJC_BIT_FEED_HALT];
            assign ro_nxt[g] = link.axis_ctrl[g][CAJC_BIT_RAPID_OVR];
            assign req_n[g] = link.axis_ctrl[g][CAJC_BIT_JOG_NEG] & jog_mode
                & ~link.axis_ctrl[g][CAJC_BIT_INHIBIT];
            assign req_p[g] = link.axis_ctrl[g][CAJC_BIT_JOG_POS] & jog_mode
                & ~link.axis_ctrl[g][CAJC_BIT_INHIBIT];
        end
    endgenerate

    always_comb begin
        jn_nxt = '0;
        jp_nxt = '0;
        used_n = '0;
        used_p = '0;
        conflict_nxt = 1'b0;
        for (int i = 0; i < CAJC_NUM_GEO; i++) begin
            if (req_n[i]) begin
                if (used_n == '0) begin
                    jn_nxt[i] = 1'b1;
                end else begin
                    conflict_nxt = 1'b1;
                end
                used_n[i] = 1'b1;
            end
            if (req_p[i]) begin
                if (used_p == '0) begin
                    jp_nxt[i] = 1'b1;
                end else begin
                    conflict_nxt = 1'b1;
                end
                used_p[i] = 1'b1;
            end
        end
        // orientation axis outside the one-axis limit
        jn_nxt[CAJC_NUM_AXES-1] = req_n[CAJC_NUM_AXES-1];
        jp_nxt[CAJC_NUM_AXES-1] = req_p[CAJC_NUM_AXES-1];
        // channel displacement
        // constant, registered so the port comes from a flop
        base_nxt = 16'(CHAN_INDEX * CAJC_CHAN_STRIDE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fh_r <= '0;
            ro_r <= '0;
            jn_r <= '0;
            jp_r <= '0;
            conflict_r <= 1'b0;
            base_r <= 16'h0000;
        end else begin
            fh_r <= fh_nxt;
            ro_r <= ro_nxt;
            jn_r <= jn_nxt;
            jp_r <= jp_nxt;
            conflict_r <= conflict_nxt;
            base_r <= base_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign link.aux_pending = pend_r;
    assign link.jog_conflict = conflict_r;

    assign program_run = run_r;
    assign action_grant = grant_r;
    assign feed_halt = fh_r;
    assign rapid_override_enable = ro_r;
    assign jog_negative = jn_r;
    assign jog_positive = jp_r;
    assign chan_base = base_r;

endmodule : cajc_channel
`default_nettype wire

/* design/cajc_host.sv */
// module: controller end writing interface bits through a register port
`timescale 1ns/1ps
`default_nettype none
module cajc_host
    import cajc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    cajc_if.host link,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    // ==========================================================
    // register file
    logic ack_r, ack_nxt;
    logic asub_r, asub_nxt;
    logic [7:0] ax_r [CAJC_NUM_AXES];
    logic [7:0] ax_nxt [CAJC_NUM_AXES];
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] axis_ofs [CAJC_NUM_AXES];
    assign axis_ofs[0] = CAJC_OFS_GEO1;
    assign axis_ofs[1] = CAJC_OFS_GEO2;
    assign axis_ofs[2] = CAJC_OFS_GEO3;
    assign axis_ofs[3] = CAJC_OFS_ORI1;
    always_comb begin
        ack_nxt = ack_r;
        asub_nxt = asub_r;
        ax_nxt = ax_r;
        rdata_nxt = 8'h00;
        if (wr) begin
            // acknowledge bit written only by software
            if (addr == CAJC_OFS_AUX_ACK) ack_nxt = wdata[CAJC_BIT_ACK];
            if (addr == CAJC_OFS_ASUB) asub_nxt = wdata[CAJC_BIT_ASUB];
            for (int i = 0; i < CAJC_NUM_AXES; i++) begin
                if (addr == axis_ofs[i]) ax_nxt[i] = wdata;
            end
        end
        if (rd) begin
            if (addr == CAJC_OFS_AUX_ACK) rdata_nxt[CAJC_BIT_ACK] = ack_r;
            if (addr == CAJC_OFS_ASUB) rdata_nxt[CAJC_BIT_ASUB] = asub_r;
            if (addr == CAJC_OFS_STATUS) rdata_nxt = {6'h00, link.jog_conflict, link.aux_pending};
            for (int i = 0; i < CAJC_NUM_AXES; i++) begin
                if (addr == axis_ofs[i]) rdata_nxt = ax_r[i];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            asub_r <= 1'b0;
            for (int i = 0; i < CAJC_NUM_AXES; i++) ax_r[i] <= CAJC_BYTE_RESET;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= ack_nxt;
            asub_r <= asub_nxt;
            ax_r <= ax_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign link.aux_function_acknowledge = ack_r;
    assign link.async_subprogram_launch = asub_r;
    assign link.axis_ctrl = ax_r;
    assign rdata = rdata_r;
endmodule : cajc_host
`default_nettype wire

/* dv/cajc_checker.sv */
// checker: interface assertions for aux acknowledge and jog conflict
`timescale 1ns/1ps
`default_nettype none
module cajc_checker
    import cajc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic aux_function_acknowledge,
    input wire logic [7:0] axis_ctrl [CAJC_NUM_AXES],
    input wire logic aux_pending,
    input wire logic jog_conflict,
    input wire logic jog_mode
);
    wire logic ack = aux_function_acknowledge;
    wire logic [2:0] ng = {axis_ctrl[2][CAJC_BIT_JOG_NEG], axis_ctrl[1][CAJC_BIT_JOG_NEG],
        axis_ctrl[0][CAJC_BIT_JOG_NEG]};
    wire logic [2:0] ps = {axis_ctrl[2][CAJC_BIT_JOG_POS], axis_ctrl[1][CAJC_BIT_JOG_POS],
        axis_ctrl[0][CAJC_BIT_JOG_POS]};
    wire logic [2:0] inh = {axis_ctrl[2][CAJC_BIT_INHIBIT], axis_ctrl[1][CAJC_BIT_INHIBIT],
        axis_ctrl[0][CAJC_BIT_INHIBIT]};
    // only requests that jog mode and inhibit let through
    wire logic [2:0] ng_act = ng & ~inh & {3{jog_mode}};
    wire logic [2:0] ps_act = ps & ~inh & {3{jog_mode}};
    wire logic mn = |(ng_act & (ng_act - 3'h1));
    wire logic mp = |(ps_act & (ps_act - 3'h1));
    wire logic [32:0] ctl = {jog_mode, axis_ctrl[3], axis_ctrl[2], axis_ctrl[1], axis_ctrl[0]};
    // ==========
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence ack_edge;
        aux_pending && $rose(ack);
    endsequence
    a_ack_resumes: assert property (ack_edge |-> ##[1:2] !aux_pending)
        else $error("pending not cleared after ack");
    a_pend_needs_ack: assert property (!$past(rst) && $fell(aux_pending) |-> ack || $past(ack))
        else $error("pending left without ack");
    a_ack_level_ignored: assert property (aux_pending && ack && $past(ack) && $past(ack, 2)
        |=> aux_pending)
        else $error("held ack taken as new ack");
    a_neg_conflict: assert property (mn ##1 mn |-> jog_conflict)
        else $error("negative conflict not flagged");
    a_pos_conflict: assert property (mp ##1 mp |-> jog_conflict)
        else $error("positive conflict not flagged");
    a_no_conflict: assert property (!(mn || mp) ##1 !(mn || mp) |-> !jog_conflict)
        else $error("conflict flagged without cause");
    a_conflict_cause: assert property (!$past(rst) && !$past(rst, 2) && $changed(jog_conflict)
        |-> $past(ctl) != $past(ctl, 2))
        else $error("conflict changed without axis change");
    a_reset_clear: assert property ($past(rst) |-> !aux_pending && !jog_conflict)
        else $error("status not clear after reset");
endmodule : cajc_checker
`default_nettype wire

/* dv/tb.sv */
// testbench: both ends joined, register port and channel inputs driven
`timescale 1ns/1ps
`default_nettype none
module tb import cajc_pkg::*;;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
    logic aux = 1'h0, areq = 1'h0, jm = 1'h0, prun, agnt;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [3:0] fh, ro, jn, jp;
    logic [15:0] cb;
    int n_mismatch = 0, checked = 0, ng = 0, g0 = 0;
    cajc_if link_if();
    cajc_host cajc_host_inst(.clk(clk), .rst(rst), .link(link_if.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    cajc_channel #(.CHAN_INDEX(2)) cajc_channel_inst(.clk(clk), .rst(rst),
        .link(link_if.device), .aux_output(aux), .action_req(areq), .jog_mode(jm),
        .program_run(prun), .action_grant(agnt), .feed_halt(fh), .rapid_override_enable(ro),
        .jog_negative(jn), .jog_positive(jp), .chan_base(cb));
    cajc_checker cajc_checker_inst(.clk(clk), .rst(rst),
        .aux_function_acknowledge(link_if.aux_function_acknowledge),
        .axis_ctrl(link_if.axis_ctrl), .aux_pending(link_if.aux_pending),
        .jog_conflict(link_if.jog_conflict), .jog_mode(jm));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (agnt === 1'h1) ng <= ng + 1;
    // ==========
    // tasks
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wreg
    task rreg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        v = rdata;
    endtask : rreg
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task wrun(input logic e);
        for (int i = 0; i < 8 && prun !== e; i++) @(posedge clk);
        #1;
        chk("program_run", 16'(e), 16'(prun));
        if (prun !== e) conclude();
    endtask : wrun
    task conclude;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // ==========
    // tests
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        wrun(1'h1);
        chk("chan_base", 16'h00c8, cb);
        for (int i = 0; i < 4; i++) begin
            wreg(CAJC_OFS_GEO1 + 8'(i), 8'h28);
            settle();
            chk("feed_halt", 16'(1 << i), 16'(fh));
            chk("rapid_ovr", 16'(1 << i), 16'(ro));
            rreg(CAJC_OFS_GEO1 + 8'(i), d);
            chk("axis_byte", 16'h0028, 16'(d));
            wreg(CAJC_OFS_GEO1 + 8'(i), 8'h00);
        end
        rreg(CAJC_OFS_AUX_CMD, d);
        chk("unmapped", 16'h0000, 16'(d));
        $display("test axis bytes done");
        @(posedge clk);
        jm <= 1'h1;
        wreg(CAJC_OFS_GEO2, 8'h40);
        settle();
        chk("jog_neg", 16'h0002, 16'(jn));
        wreg(CAJC_OFS_GEO1, 8'h40);
        settle();
        chk("jog_neg", 16'h0001, 16'(jn));
        rreg(CAJC_OFS_STATUS, d);
        chk("status", 16'h0002, 16'(d));
        wreg(CAJC_OFS_GEO1, 8'h00);
        wreg(CAJC_OFS_GEO2, 8'h80);
        wreg(CAJC_OFS_GEO3, 8'h80);
        wreg(CAJC_OFS_ORI1, 8'h80);
        settle();
        chk("jog_pos", 16'h000a, 16'(jp));
        wreg(CAJC_OFS_GEO3, 8'h00);
        wreg(CAJC_OFS_GEO2, 8'h90);
        settle();
        chk("jog_pos", 16'h0008, 16'(jp));
        wreg(CAJC_OFS_GEO2, 8'h80);
        settle();
        chk("jog_pos", 16'h000a, 16'(jp));
        @(posedge clk);
        jm <= 1'h0;
        settle();
        chk("jog_pos", 16'h0000, 16'(jp));
        $display("test jog done");
        @(posedge clk);
        aux <= 1'h1;
        @(posedge clk);
        aux <= 1'h0;
        wrun(1'h0);
        rreg(CAJC_OFS_STATUS, d);
        chk("status", 16'h0001, 16'(d));
        g0 = ng;
        @(posedge clk);
        areq <= 1'h1;
        @(posedge clk);
        areq <= 1'h0;
        settle();
        chk("grant", 16'(g0), 16'(ng));
        wreg(CAJC_OFS_AUX_ACK, 8'h01);
        wrun(1'h1);
        settle();
        chk("grant_deferred", 16'(g0 + 1), 16'(ng));
        @(posedge clk);
        aux <= 1'h1;
        @(posedge clk);
        aux <= 1'h0;
        wrun(1'h0);
        repeat (4) @(posedge clk);
        #1;
        chk("program_run", 16'h0000, 16'(prun));
        wreg(CAJC_OFS_AUX_ACK, 8'h00);
        wreg(CAJC_OFS_AUX_ACK, 8'h01);
        wrun(1'h1);
        rreg(CAJC_OFS_AUX_ACK, d);
        chk("ack_byte", 16'h0001, 16'(d));
        g0 = ng;
        @(posedge clk);
        areq <= 1'h1;
        @(posedge clk);
        areq <= 1'h0;
        settle();
        chk("grant", 16'(g0 + 1), 16'(ng));
        $display("test aux ack done");
        conclude();
    end
endmodule : tb
`default_nettype wire
